// ===== core/hpc_params.svh
// Constants for the host port controller of a two-port static memory.
// Assumes a 100 MHz clock and the slower speed grade of the memory.
`ifndef HPC_PARAMS_SVH
`define HPC_PARAMS_SVH

`define HPC_CLK_NS 10
// Least times round up to whole clock cycles.
`define HPC_CYC(ns) (((ns) + `HPC_CLK_NS - 1) / `HPC_CLK_NS)

`define HPC_ARB_SETUP_NS 5
`define HPC_FLAG_ASSERT_FROM_MATCH_NS 20
`define HPC_WRITE_PULSE_NS 15
`define HPC_WRITE_HOLD_AFTER_RELEASE_NS 15
`define HPC_RELEASE_TO_DATA_DELAY_NS 17
`define HPC_ACCESS_NS 20
`define HPC_SYNC_CYC 2

`define HPC_LEFT_MAILBOX 16'hfffe
`define HPC_RIGHT_MAILBOX 16'hffff

`endif

// ===== core/hpc_pkg.sv
// Types shared by the host port controller.
// Assumes the constants header is compiled alongside.
package hpc_pkg;

   typedef enum logic [4:0] {
      HPC_IDLE = 5'h01,
      HPC_SETTLE = 5'h02,
      HPC_STROBE = 5'h04,
      HPC_END = 5'h08,
      HPC_INIT = 5'h10
   } hpc_state_t;

   // Pins that the controller drives on its memory port.
   typedef struct packed {
      logic [15:0] addr;
      logic cs_n;
      logic rw_n;
      logic oe_n;
      logic data_oe;
      logic [8:0] data;
   } hpc_pins_t;

endpackage

// ===== core/hpc_port_ctrl.sv
// Host controller for one port of an asynchronous two-port static memory.
// Assumes the memory pins are asynchronous to mclk_i; every pin input is
// synchronised. The data bus is split into output, enable and input.
//
// How it works
// R1 - Master drives both collision flags; slave takes them as inputs.
// R2 - Slave blocks a port's writes while its collision flag input is low.
// R3 - Master flags the later of two ports selecting the same address.
// R4 - Too-close arrivals still flag exactly one side, never both.
// R5 - Present address and select at least 5 ns before strobing to win.
// R6 - A slave does no arbitration; ordering margin does not matter there.
// R7 - Master discards a port's writes while it drives that flag low.
// R8 - Master asserts flag within 15/20 ns, releases within 15/17 ns.
// R9 - Collision flag input to a slave is valid by the write strobe start.
// R10 - Hold write strobe 12/15 ns after the collision flag rises.
// R11 - Written data reaches the far port within 30/25 ns.
// R12 - Read data is valid a computed delay after the flag releases.
// R13 - Writing the far mailbox word lowers the far mail flag.
// R14 - Right mail flag clears on a right read of FFFF.
// R15 - Left mail flag clears on a left access of FFFE with output enable.
// R16 - Mail flags set and clear within 15 ns, or 20 ns slow grade.
// R17 - Controllers bring mail flags to a known state after power-up.
// R18 - Collision decisions use only address and chip select.
// R19 - Unused mailbox words are ordinary storage.
// R20 - Differing addresses or a deselect keep both flags high.
// R21 - A blocked mailbox access leaves the mail flag unchanged.
`timescale 1ns/1ps
`include "hpc_params.svh"

module hpc_port_ctrl
   import hpc_pkg::*;
#(
   parameter bit IS_LEFT = 1'b1
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic req_i,
   input wire logic req_write_i,
   input wire logic [15:0] req_addr_i,
   input wire logic [8:0] req_wdata_i,
   input wire logic block_req_i,
   output hpc_pins_t pins_o,
   output logic block_n_o,
   input wire logic [8:0] data_i,
   input wire logic collision_flag_i,
   input wire logic mail_flag_i,
   output logic ready_o,
   output logic done_o,
   output logic [8:0] rdata_o,
   output logic mail_pending_o
);

   localparam logic [15:0] OWN_MAILBOX = IS_LEFT ? `HPC_LEFT_MAILBOX : `HPC_RIGHT_MAILBOX;
   // The flag may take its full assert time and then the synchroniser.
   localparam logic [3:0] SETTLE_CYC = 4'(`HPC_CYC(`HPC_FLAG_ASSERT_FROM_MATCH_NS)
      + `HPC_SYNC_CYC);
   localparam logic [3:0] ARB_CYC = 4'(`HPC_CYC(`HPC_ARB_SETUP_NS));
   localparam logic [3:0] WP_CYC = 4'(`HPC_CYC(`HPC_WRITE_PULSE_NS));
   localparam logic [3:0] WH_CYC = 4'(`HPC_CYC(`HPC_WRITE_HOLD_AFTER_RELEASE_NS));
   localparam logic [3:0] RD_CYC = 4'(`HPC_CYC(`HPC_ACCESS_NS) + `HPC_SYNC_CYC);
   localparam logic [3:0] RDB_CYC = 4'(`HPC_CYC(`HPC_RELEASE_TO_DATA_DELAY_NS)
      + `HPC_SYNC_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   logic [10:0] sync1_reg;
   logic [10:0] sync2_reg;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync1_reg <= 11'h7ff;
         sync2_reg <= 11'h7ff;
      end else begin
         sync1_reg <= {collision_flag_i, mail_flag_i, data_i};
         sync2_reg <= sync1_reg;
      end
   end

   logic coll_s;
   logic mail_s;
   logic [8:0] data_s;
   assign coll_s = sync2_reg[10];
   assign mail_s = sync2_reg[9];
   assign data_s = sync2_reg[8:0];

   ////////////////////////////////////////////////////////////////////////////
   // Access sequencer.

   hpc_state_t state_reg, state_next;
   hpc_pins_t pins_reg, pins_next;
   logic [3:0] cnt_reg, cnt_next;
   logic init_reg, init_next;
   logic block_n_reg, block_n_next;
   logic ready_reg, ready_next;
   logic done_reg, done_next;
   logic [8:0] rdata_reg, rdata_next;
   logic mail_reg, mail_next;
   // Write intent is kept apart from the strobe pin, which must stay high while arbitration settles.
   logic wr_reg, wr_next;

   always_comb begin
      state_next = state_reg;
      pins_next = pins_reg;
      cnt_next = cnt_reg;
      init_next = init_reg;
      block_n_next = block_n_reg;
      ready_next = 1'b0;
      done_next = 1'b0;
      rdata_next = rdata_reg;
      mail_next = !mail_s;
      wr_next = wr_reg;
      case (state_reg)
         HPC_INIT: begin
            // The memory has no reset, so the own mail flag is cleared here.
            pins_next.addr = OWN_MAILBOX; // R17
            pins_next.cs_n = 1'b0;
            cnt_next = SETTLE_CYC;
            state_next = HPC_SETTLE;
         end
         HPC_IDLE: begin
            ready_next = 1'b1;
            if (req_i && ready_reg) begin
               ready_next = 1'b0;
               pins_next.addr = req_addr_i;
               pins_next.data = req_wdata_i;
               wr_next = req_write_i;
               pins_next.cs_n = 1'b0;
               // Address and select lead every strobe by the arbitration margin.
               cnt_next = (SETTLE_CYC > ARB_CYC) ? SETTLE_CYC : ARB_CYC; // R5
               block_n_next = !block_req_i; // R9
               state_next = HPC_SETTLE;
            end
         end
         HPC_SETTLE: begin
            if (cnt_reg > 4'h1) begin
               cnt_next = cnt_reg - 4'h1;
            end else if (!init_reg && wr_reg) begin
               state_next = HPC_STROBE;
               pins_next.rw_n = 1'b0;
               pins_next.data_oe = 1'b1;
               cnt_next = WP_CYC;
            end else begin
               state_next = HPC_STROBE;
               pins_next.oe_n = 1'b0;
               cnt_next = RD_CYC;
            end
         end
         HPC_STROBE: begin
            if (!coll_s) begin
               // A blocked write must outlast the flag release to complete.
               cnt_next = pins_reg.rw_n ? RDB_CYC : WH_CYC; // R10 R12
            end else if (cnt_reg > 4'h1) begin
               cnt_next = cnt_reg - 4'h1;
            end else begin
               pins_next.rw_n = 1'b1;
               pins_next.data_oe = 1'b0;
               pins_next.oe_n = 1'b1;
               pins_next.cs_n = 1'b1;
               if (!pins_reg.oe_n) begin
                  rdata_next = data_s;
               end
               done_next = !init_reg;
               init_next = 1'b0;
               block_n_next = 1'b1;
               state_next = HPC_END;
            end
         end
         HPC_END: begin
            ready_next = 1'b1;
            state_next = HPC_IDLE;
         end
         default: begin
            state_next = HPC_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= HPC_INIT;
         pins_reg <= '{addr: 16'h0000, cs_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1,
            data_oe: 1'b0, data: 9'h000};
         cnt_reg <= 4'h0;
         init_reg <= 1'b1;
         block_n_reg <= 1'b1;
         ready_reg <= 1'b0;
         done_reg <= 1'b0;
         rdata_reg <= 9'h000;
         mail_reg <= 1'b0;
         wr_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         pins_reg <= pins_next;
         cnt_reg <= cnt_next;
         init_reg <= init_next;
         block_n_reg <= block_n_next;
         ready_reg <= ready_next;
         done_reg <= done_next;
         rdata_reg <= rdata_next;
         mail_reg <= mail_next;
         wr_reg <= wr_next;
      end
   end

   assign pins_o = pins_reg;
   assign block_n_o = block_n_reg;
   assign ready_o = ready_reg;
   assign done_o = done_reg;
   assign rdata_o = rdata_reg;
   assign mail_pending_o = mail_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   sequence s_select_quiet;
      pins_reg.rw_n && pins_reg.oe_n && !pins_reg.cs_n;
   endsequence

   a_arb_lead: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R5
      $fell(pins_reg.cs_n) |-> s_select_quiet ##1 s_select_quiet)
      else $error("strobe came before the arbitration margin");

   a_block_steady: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R9
      (!pins_reg.rw_n && !pins_reg.cs_n) |-> $stable(block_n_reg))
      else $error("slave block level changed during a write strobe");

   sequence s_write_held;
      (!pins_reg.rw_n) [*2];
   endsequence

   a_write_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R10
      (!pins_reg.rw_n && $rose(coll_s)) |-> s_write_held)
      else $error("write strobe released too soon after flag release");

   a_init_mailbox: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R17
      ($fell(pins_reg.cs_n) && init_reg) |-> pins_reg.addr == OWN_MAILBOX
      ##[1:8] !pins_reg.oe_n)
      else $error("power-up mailbox read missing");

   a_done_single: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      done_reg |-> pins_reg.cs_n ##1 (!done_reg && ready_reg))
      else $error("done pulse malformed");

endmodule

// ===== verif/hpc_mem_model.sv
// Two-port memory with collision and mailbox logic in master mode.
// Assumes the left port is the controller under test; the bench drives the right.
`timescale 1ns/1ps
module hpc_mem_model
   import hpc_pkg::*;
(
   input wire hpc_pins_t lp_i,
   input wire logic [15:0] r_addr_i,
   input wire logic r_cs_n_i,
   input wire logic r_rw_n_i,
   input wire logic r_oe_n_i,
   input wire logic l_block_n_i,
   output logic [8:0] l_data_o,
   output logic l_coll_n_o,
   output logic r_coll_n_o,
   output logic l_mail_n_o,
   output logic r_mail_n_o
);
   logic [8:0] mem [int];
   logic [8:0] smem [int];
   logic [8:0] last = 9'h000;
   realtime tl = 0;
   realtime tr = 0;
   logic match;
   ////////////////////////////////////////////////////////////////////////////
   // The side whose address and select settled later is the one flagged.
   always @(lp_i.addr or lp_i.cs_n) tl = $realtime;
   always @(r_addr_i or r_cs_n_i) tr = $realtime;
   assign match = (lp_i.addr == r_addr_i) && !lp_i.cs_n && !r_cs_n_i;
   assign #15 l_coll_n_o = !(match && tl >= tr);
   assign #15 r_coll_n_o = !(match && tr > tl);
   ////////////////////////////////////////////////////////////////////////////
   // A strobe held past the flag release still lands, so writes are level based.
   always @(lp_i or l_coll_n_o or l_block_n_i) begin
      if (!lp_i.cs_n && !lp_i.rw_n && l_coll_n_o) begin
         mem[lp_i.addr] = lp_i.data;
      end
      // A slave beside the master has no arbiter; only its flag input gates writes.
      if (!lp_i.cs_n && !lp_i.rw_n && l_block_n_i) begin
         smem[lp_i.addr] = lp_i.data;
      end
      if (!lp_i.cs_n && !lp_i.oe_n) begin
         l_data_o = mem.exists(lp_i.addr) ? mem[lp_i.addr] : 9'h000;
         last = l_data_o;
      end else begin
         l_data_o = ~last;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Flags power up asserted, so the start-up clears are really exercised.
   initial begin
      l_mail_n_o = 1'b0;
      r_mail_n_o = 1'b0;
   end
   always @(lp_i or r_addr_i or r_cs_n_i or r_rw_n_i or r_oe_n_i or l_coll_n_o) begin
      if (!lp_i.cs_n && !lp_i.rw_n && lp_i.addr == 16'hffff && l_coll_n_o) begin
         r_mail_n_o <= #15 1'b0;
      end
      if (!r_cs_n_i && !r_oe_n_i && r_addr_i == 16'hffff && r_coll_n_o) begin
         r_mail_n_o <= #15 1'b1;
      end
      if (!r_cs_n_i && !r_rw_n_i && r_addr_i == 16'hfffe && r_coll_n_o) begin
         l_mail_n_o <= #15 1'b0;
      end
      if (!lp_i.cs_n && !lp_i.oe_n && lp_i.addr == 16'hfffe && l_coll_n_o) begin
         l_mail_n_o <= #15 1'b1;
      end
   end
endmodule

// ===== verif/testbench.sv
// Self-checking bench: left port controller against the memory model.
// Assumes the bench plays the right-hand processor directly on the pins.
`timescale 1ns/1ps
module testbench;
   import hpc_pkg::*;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic req_i = 1'b0;
   logic req_write_i = 1'b0;
   logic [15:0] req_addr_i = 16'h0000;
   logic [8:0] req_wdata_i = 9'h000;
   logic block_req_i = 1'b0;
   logic [15:0] r_addr = 16'h0000;
   logic r_cs_n = 1'b1;
   logic r_rw_n = 1'b1;
   logic r_oe_n = 1'b1;
   hpc_pins_t pins;
   logic block_n, ready_o, done_o, mail_pending_o, l_coll, r_coll, l_mail, r_mail;
   logic [8:0] l_data, rdata_o, d0, d1;
   logic [15:0] a;
   logic [8:0] exp_mem [int];
   int errors = 0;
   int n_checks = 0;
   always #5 mclk_i = ~mclk_i;
   hpc_port_ctrl #(.IS_LEFT(1'b1)) u_dut (.mclk_i, .nrst_i, .req_i, .req_write_i,
      .req_addr_i, .req_wdata_i, .block_req_i, .pins_o(pins), .block_n_o(block_n),
      .data_i(l_data), .collision_flag_i(l_coll), .mail_flag_i(l_mail), .ready_o,
      .done_o, .rdata_o, .mail_pending_o);
   hpc_mem_model u_mem (.lp_i(pins), .r_addr_i(r_addr), .r_cs_n_i(r_cs_n),
      .r_rw_n_i(r_rw_n), .r_oe_n_i(r_oe_n), .l_block_n_i(block_n), .l_data_o(l_data),
      .l_coll_n_o(l_coll),
      .r_coll_n_o(r_coll), .l_mail_n_o(l_mail), .r_mail_n_o(r_mail));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // A request is offered only while ready is high, so nothing is refused.
   task automatic acc(input logic wr, input logic [15:0] ad, input logic [8:0] d);
      int n;
      n = 0;
      while (ready_o !== 1'b1 && n < 300) begin
         @(negedge mclk_i);
         n++;
      end
      req_i = 1'b1;
      req_write_i = wr;
      req_addr_i = ad;
      req_wdata_i = d;
      @(negedge mclk_i);
      req_i = 1'b0;
      n = 0;
      while (done_o !== 1'b1 && n < 300) begin
         @(negedge mclk_i);
         n++;
      end
      chk({8'h00, done_o}, 9'h001);
      chk({8'h00, block_n}, 9'h001);
      if (wr) begin
         exp_mem[ad] = d;
      end
   endtask
   task automatic rd_chk(input logic [15:0] ad);
      acc(1'b0, ad, 9'h000);
      chk(rdata_o, exp_mem[ad]);
   endtask
   task automatic rside(input logic [15:0] ad, input logic rw, input logic oe);
      @(negedge mclk_i);
      r_addr = ad;
      r_cs_n = 1'b0;
      r_rw_n = rw;
      r_oe_n = oe;
      repeat (4) @(negedge mclk_i);
      r_cs_n = 1'b1;
      r_rw_n = 1'b1;
      r_oe_n = 1'b1;
   endtask
   task report_and_stop;
      $display("errors=%0d n_checks=%0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(38259));
      repeat (2) @(negedge mclk_i);
      nrst_i = 1'b1;
      rside(16'hffff, 1'b1, 1'b0);
      acc(1'b1, 16'h0000, 9'h000);
      chk({8'h00, l_mail}, 9'h001);
      for (int i = 0; i < 6; i++) begin
         a = 16'($urandom) & 16'h7fff;
         acc(1'b1, a, 9'($urandom));
         rd_chk(a);
      end
      acc(1'b1, 16'hffff, 9'($urandom));
      chk({8'h00, r_mail}, 9'h000);
      rside(16'hffff, 1'b1, 1'b0);
      chk({8'h00, r_mail}, 9'h001);
      rd_chk(16'hffff);
      rside(16'hfffe, 1'b0, 1'b1);
      repeat (6) @(negedge mclk_i);
      chk({8'h00, mail_pending_o}, 9'h001);
      acc(1'b0, 16'hfffe, 9'h000);
      repeat (6) @(negedge mclk_i);
      chk({8'h00, mail_pending_o}, 9'h000);
      a = 16'($urandom) & 16'h7fff;
      d0 = 9'($urandom);
      d1 = ~d0;
      acc(1'b1, a, d0);
      @(negedge mclk_i);
      r_addr = a;
      r_cs_n = 1'b0;
      fork
         acc(1'b1, a, d1);
         begin
            repeat (20) @(negedge mclk_i);
            chk({7'h00, l_coll, r_coll}, 9'h001);
            chk(u_mem.mem[a], d0);
            chk({8'h00, ready_o}, 9'h000);
            r_cs_n = 1'b1;
         end
      join
      rd_chk(a);
      // A slave-blocked write must miss the slave but still reach the master.
      block_req_i = 1'b1;
      fork
         acc(1'b1, a, d0);
         begin
            repeat (4) @(negedge mclk_i);
            chk({8'h00, block_n}, 9'h000);
         end
      join
      block_req_i = 1'b0;
      chk(u_mem.smem[a], d1);
      rd_chk(a);
      report_and_stop;
   end
   initial begin
      #100000;
      errors++;
      $display("MISMATCH %0t watchdog expired", $time);
      report_and_stop;
   end
endmodule
